// ---- tsc_params.svh ----
// constants of the tuning store command unit: register offsets, fields, codes, timing
// assumes inclusion by the package and by each design file that needs them
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

// apb byte offsets
`define TSC_OFS_CMD     8'h00
`define TSC_OFS_TUNE    8'h04
`define TSC_OFS_PROG    8'h08
`define TSC_OFS_ANA     8'h0C
`define TSC_OFS_STAT    8'h10
`define TSC_OFS_WORD    8'h14

// program word fields (lsb positions)
`define TSC_W_MS        15
`define TSC_W_BAND      13
`define TSC_W_TUNE      1
`define TSC_W_SKIP      0

// command and source codes
`define TSC_CMD_NONE    4'h0
`define TSC_CMD_STPROG  4'h1
`define TSC_CMD_STANA   4'h2
`define TSC_CMD_BAND    4'h3
`define TSC_CMD_MSSEQ   4'h4
`define TSC_CMD_NORM    4'h5
`define TSC_CMD_MADDR   4'h6
`define TSC_CMD_SKIP    4'h7
`define TSC_SRC_KEYPAD  2'h0
`define TSC_SRC_DATA    2'h1
`define TSC_SRC_REMOTE  2'h2

// sizes and reset values
`define TSC_PROG_WORDS  5'h14
`define TSC_ANA_LAST    2'h3
`define TSC_RST_PROG    5'h00

// timing
`define TSC_CLK_HZ      10000000
`define TSC_FLASH_HZ    5
`define TSC_FLASH_MS    1000
`define TSC_FLASH_HALF_CYC (`TSC_CLK_HZ / (2 * `TSC_FLASH_HZ))
`define TSC_FLASH_HALVES   (`TSC_FLASH_MS * 2 * `TSC_FLASH_HZ / 1000)

`endif

// ---- tsc_pkg.sv ----
// types of the tuning store command unit
// assumes tsc_params.svh beside it
package tsc_pkg;
  `include "tsc_params.svh"

  typedef enum logic [3:0] {
    cmd_none   = `TSC_CMD_NONE,
    cmd_stprog = `TSC_CMD_STPROG,
    cmd_stana  = `TSC_CMD_STANA,
    cmd_band   = `TSC_CMD_BAND,
    cmd_msseq  = `TSC_CMD_MSSEQ,
    cmd_norm   = `TSC_CMD_NORM,
    cmd_maddr  = `TSC_CMD_MADDR,
    cmd_skip   = `TSC_CMD_SKIP
  } tsc_cmd_t;

  typedef enum logic [1:0] {
    keypad_source = `TSC_SRC_KEYPAD,
    data_source   = `TSC_SRC_DATA,
    remote_source = `TSC_SRC_REMOTE,
    bad_source    = 2'h3
  } tsc_src_t;

  typedef enum logic [1:0] {st_idle, st_ana_wr, st_norm} tsc_state_t;

  typedef struct packed {
    tsc_state_t        state;
    logic [1:0]        idx;
    logic              addr_pend;
    logic [4:0]        prog_addr;
    logic              skip_flag;
    logic [11:0]       tune;
    logic [1:0]        band;
    logic [1:0]        ms;
    logic [3:0][5:0]   ana_cnt;
    logic [3:0][5:0]   ana_mem;
    logic [3:0][5:0]   ana_out;
    logic              ana_en;
    logic [19:0][16:0] prog_mem;
    logic              flash_go;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } tsc_st_t;

  typedef struct packed {
    logic [19:0] cnt;
    logic [3:0]  halves;
    logic        active;
    logic        lit;
  } tsc_flash_st_t;
endpackage : tsc_pkg

// ---- tsc_flash_if.sv ----
// link between the command unit and its confirmation flasher
// assumes both ends on the same pclk
`timescale 1ns/1ns
interface tsc_flash_if;
  logic start;
  logic active;
  logic lit;
  modport ctl (output start, input active, input lit);
  modport tmr (input start, output active, output lit);
endinterface : tsc_flash_if

// ---- tsc_flash.sv ----
// display confirmation flasher: 5 Hz blink for 1 s after a start pulse
// assumes pclk at 10 MHz and a one-cycle start pulse
`timescale 1ns/1ns
`include "tsc_params.svh"
module tsc_flash
  import tsc_pkg::*;
#(
  parameter int unsigned HALF_CYC = `TSC_FLASH_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  tsc_flash_if.tmr fl
);
  tsc_flash_st_t s;
  tsc_flash_st_t next_s;

  always_comb begin
    next_s = s;
    if (fl.start) begin
      // a fresh start restarts the whole second
      next_s.active = 1'b1;
      next_s.lit    = 1'b0;
      next_s.cnt    = 20'h0_0000;
      next_s.halves = 4'h0;
    end else if (s.active) begin
      next_s.cnt = s.cnt + 20'h0_0001;
      if (s.cnt == 20'(HALF_CYC - 1)) begin
        next_s.cnt    = 20'h0_0000;
        next_s.lit    = !s.lit;
        next_s.halves = s.halves + 4'h1;
        if (s.halves == 4'(`TSC_FLASH_HALVES - 1)) begin
          next_s.active = 1'b0;
          next_s.lit    = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{cnt: 20'h0_0000, halves: 4'h0, active: 1'b0, lit: 1'b1};
    end else begin
      s <= next_s;
    end
  end

  assign fl.active = s.active;
  assign fl.lit    = s.lit;

  idle_lit_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s.active |-> s.lit) else $error("display dark while flasher idle");
endmodule : tsc_flash

// ---- tsc_store_unit.sv ----
// tuning store command unit: executes store, sequence, normalise and skip commands
// assumes an apb master on pclk and a single synchronous option select level
//
// How it works
// - store program writes counters to addressed word
// - store program clears that word's skip bit
// - confirm with 5 Hz flash for 1 s
// - store analog writes memories one by one
// - band sequence advances one band per strobe
// - multi standard sequence adds one per strobe
// - normalise reloads converters from memories in turn
// - analog outputs disabled during normalise
// - after addressing, next selection is store target
// - set skip marks the selected program word
// - skip defeat input ignores skip bits
// - keypad only, except normalise from any source
// - word is ms, band, tuning, skip bit
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "tsc_params.svh"
module tsc_store_unit
  import tsc_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC = `TSC_FLASH_HALF_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        option_select_input,
  output logic [11:0]      tuning_out,
  output logic [1:0]       band_out,
  output logic [1:0]       multi_standard_out,
  output logic [23:0]      analog_out,
  output logic             analog_enable,
  output logic             display_on
);
  tsc_st_t      s;
  tsc_st_t      next_s;
  tsc_flash_if  fl ();

  logic         acc;
  logic         wr;
  logic         req;
  tsc_cmd_t     cmd;
  tsc_src_t     src;
  logic         cmd_ok;
  logic         prog_wr;
  logic [16:0]  sel_word;
  logic [16:0]  cur_word;
  logic [5:0]   cnt_at_idx;
  logic [5:0]   mem_at_idx;

  tsc_flash #(.HALF_CYC(FLASH_HALF_CYC)) u_flash (
    .pclk    (pclk),
    .presetn (presetn),
    .fl      (fl)
  );

  // apb access completes in the cycle where pready is high
  assign acc      = psel && penable && s.pready;
  assign wr       = acc && pwrite;
  assign req      = psel && penable && !s.pready;
  assign cmd      = tsc_cmd_t'(pwdata[3:0]);
  assign src      = tsc_src_t'(pwdata[5:4]);
  assign prog_wr  = wr && (paddr == `TSC_OFS_PROG) && (pwdata[4:0] < `TSC_PROG_WORDS);
  assign sel_word = s.prog_mem[pwdata[4:0]];
  assign cur_word = {s.ms, s.band, s.tune, 1'b0};
  assign cnt_at_idx = s.ana_cnt[s.idx];
  assign mem_at_idx = s.ana_mem[s.idx];
  assign fl.start   = s.flash_go;

  assign cmd_ok = wr && (paddr == `TSC_OFS_CMD) && (s.state == st_idle)
                  && ((src == keypad_source)
                      || ((cmd == cmd_norm) && (src != bad_source)));

  always_comb begin
    next_s          = s;
    next_s.flash_go = 1'b0;
    next_s.pready   = req;
    next_s.pslverr  = 1'b0;
    next_s.prdata   = 32'h0000_0000;

    // analog sequencer, one channel per cycle
    unique case (s.state)
      st_idle: begin
      end
      st_ana_wr: begin
        next_s.ana_mem[s.idx] = s.ana_cnt[s.idx];
        next_s.idx            = s.idx + 2'h1;
        if (s.idx == `TSC_ANA_LAST) begin
          next_s.state    = st_idle;
          next_s.flash_go = 1'b1;
        end
      end
      st_norm: begin
        next_s.ana_out[s.idx] = s.ana_mem[s.idx];
        next_s.idx            = s.idx + 2'h1;
        if (s.idx == `TSC_ANA_LAST) begin
          next_s.state  = st_idle;
          next_s.ana_en = 1'b1;
        end
      end
    endcase

    if (cmd_ok) begin
      unique case (cmd)
        cmd_stprog: begin
          next_s.prog_mem[s.prog_addr] = cur_word;
          next_s.skip_flag             = 1'b0;
          next_s.flash_go              = 1'b1;
        end
        cmd_stana: begin
          next_s.state = st_ana_wr;
          next_s.idx   = 2'h0;
        end
        cmd_band: begin
          next_s.band = s.band + 2'h1;
        end
        cmd_msseq: begin
          next_s.ms = s.ms + 2'h1;
        end
        cmd_norm: begin
          next_s.state  = st_norm;
          next_s.idx    = 2'h0;
          next_s.ana_en = 1'b0;
        end
        cmd_maddr: begin
          next_s.addr_pend = 1'b1;
        end
        cmd_skip: begin
          next_s.prog_mem[s.prog_addr][`TSC_W_SKIP] = 1'b1;
          next_s.skip_flag                          = 1'b1;
          next_s.flash_go                           = 1'b1;
        end
        default: begin
        end
      endcase
    end

    if (prog_wr) begin
      next_s.prog_addr = pwdata[4:0];
      if (s.addr_pend) begin
        next_s.prog_mem[pwdata[4:0]] = cur_word;
        next_s.addr_pend             = 1'b0;
        next_s.skip_flag             = 1'b0;
        next_s.flash_go              = 1'b1;
      end else if (!sel_word[`TSC_W_SKIP] || option_select_input) begin
        // recall skipped words only under defeat
        next_s.ms        = sel_word[`TSC_W_MS +: 2];
        next_s.band      = sel_word[`TSC_W_BAND +: 2];
        next_s.tune      = sel_word[`TSC_W_TUNE +: 12];
        next_s.skip_flag = sel_word[`TSC_W_SKIP];
      end
    end

    if (wr && (paddr == `TSC_OFS_TUNE)) begin
      next_s.ms   = pwdata[13:12];
      next_s.band = pwdata[15:14];
      next_s.tune = pwdata[11:0];
    end
    if (wr && (paddr == `TSC_OFS_ANA)) begin
      next_s.ana_cnt = pwdata[23:0];
    end

    if (req) begin
      unique case (paddr)
        `TSC_OFS_CMD: next_s.prdata = {31'h0000_0000, s.state != st_idle};
        `TSC_OFS_TUNE: next_s.prdata = {16'h0000, s.band, s.ms, s.tune};
        `TSC_OFS_PROG: next_s.prdata = {27'h000_0000, s.prog_addr};
        `TSC_OFS_ANA: next_s.prdata = {8'h00, s.ana_cnt};
        `TSC_OFS_STAT: next_s.prdata = {26'h000_0000, option_select_input,
                                        s.skip_flag, s.addr_pend, s.ana_en,
                                        fl.active, s.state != st_idle};
        `TSC_OFS_WORD: next_s.prdata = {15'h0000, s.prog_mem[s.prog_addr]};
        default: next_s.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.state     <= st_idle;
      s.prog_addr <= `TSC_RST_PROG;
      s.ana_en    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata             = s.prdata;
  assign pready             = s.pready;
  assign pslverr            = s.pslverr;
  assign tuning_out         = s.tune;
  assign band_out           = s.band;
  assign multi_standard_out = s.ms;
  assign analog_out         = s.ana_out;
  assign analog_enable      = s.ana_en;
  assign display_on         = fl.lit;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  store_prog_word_a: assert property (
    (cmd_ok && cmd == cmd_stprog && !prog_wr)
      |=> s.prog_mem[$past(s.prog_addr)][16:1] == $past(cur_word[16:1]))
    else $error("stored word differs from counters");

  store_skip_clr_a: assert property (
    (cmd_ok && cmd == cmd_stprog && !prog_wr)
      |=> !s.prog_mem[$past(s.prog_addr)][0] && !s.skip_flag)
    else $error("skip bit survived store");

  store_flash_a: assert property (
    (cmd_ok && (cmd == cmd_stprog || cmd == cmd_skip))
      |-> ##2 (fl.active && !fl.lit))
    else $error("no confirmation flash after store");

  ana_write_a: assert property (
    (s.state == st_ana_wr)
      |=> s.ana_mem[$past(s.idx)] == $past(cnt_at_idx))
    else $error("analog memory not written from counter");

  ana_seq_len_a: assert property (
    (cmd_ok && cmd == cmd_stana)
      |=> (s.state == st_ana_wr) [*4] ##1 (s.state == st_idle) ##1 fl.active)
    else $error("analog store sequence length wrong");

  band_step_a: assert property (
    (cmd_ok && cmd == cmd_band && !prog_wr)
      |=> s.band == 2'($past(s.band) + 2'h1))
    else $error("band did not step once");

  ms_step_a: assert property (
    (cmd_ok && cmd == cmd_msseq && !prog_wr)
      |=> s.ms == 2'($past(s.ms) + 2'h1))
    else $error("multi standard did not step once");

  ms_wrap_a: assert property (
    (cmd_ok && cmd == cmd_msseq && !prog_wr && s.ms == 2'h3) |=> s.ms == 2'h0)
    else $error("multi standard did not wrap");

  norm_load_a: assert property (
    (s.state == st_norm)
      |=> s.ana_out[$past(s.idx)] == $past(mem_at_idx))
    else $error("converter not reloaded from memory");

  norm_off_a: assert property (
    (cmd_ok && cmd == cmd_norm)
      |=> !analog_enable [*4] ##1 analog_enable)
    else $error("analog outputs not held off during normalise");

  maddr_target_a: assert property (
    (prog_wr && s.addr_pend)
      |=> $stable(s.tune) && !s.addr_pend && s.prog_addr == $past(pwdata[4:0])
          && s.prog_mem[s.prog_addr][16:1] == $past(cur_word[16:1]))
    else $error("post tuning selection recalled instead of stored");

  set_skip_a: assert property (
    (cmd_ok && cmd == cmd_skip && !prog_wr)
      |=> s.prog_mem[$past(s.prog_addr)][0] && s.skip_flag)
    else $error("skip bit not set");

  skip_hold_a: assert property (
    (prog_wr && !s.addr_pend && sel_word[0] && !option_select_input)
      |=> $stable(s.tune) && $stable(s.band) && $stable(s.ms))
    else $error("skipped program recalled without defeat");

  source_gate_a: assert property (
    (wr && paddr == `TSC_OFS_CMD && src != keypad_source && cmd == cmd_maddr)
      |=> s.addr_pend == $past(s.addr_pend))
    else $error("keypad only command taken from other source");

  maddr_flash_a: assert property (
    (prog_wr && s.addr_pend)
      |-> ##2 (fl.active && !fl.lit))
    else $error("no confirmation flash after post tuning store");

  ana_flash_a: assert property (
    (s.state == st_ana_wr && s.idx == `TSC_ANA_LAST)
      |-> ##2 (fl.active && !fl.lit))
    else $error("no confirmation flash after analog store");

  recall_word_a: assert property (
    (prog_wr && !s.addr_pend && (!sel_word[0] || option_select_input))
      |=> {s.ms, s.band, s.tune, s.skip_flag} == $past(sel_word))
    else $error("selected program not recalled into counters");

  ana_en_norm_a: assert property (
    analog_enable == (s.state != st_norm))
    else $error("analog enable out of step with normalise");

  keypad_only_a: assert property (
    (wr && paddr == `TSC_OFS_CMD && s.state == st_idle && src != keypad_source
     && cmd != cmd_norm)
      |=> $stable(s.band) && $stable(s.ms) && $stable(s.prog_mem) && $stable(s.state))
    else $error("store or sequence taken from other source");

  norm_any_src_a: assert property (
    (wr && paddr == `TSC_OFS_CMD && s.state == st_idle && cmd == cmd_norm
     && (src == data_source || src == remote_source))
      |=> s.state == st_norm && !analog_enable)
    else $error("normalise refused from data or remote");

  bad_src_a: assert property (
    (wr && paddr == `TSC_OFS_CMD && s.state == st_idle && src == bad_source)
      |=> $stable(s.ana_en) && $stable(s.addr_pend) && $stable(s.band))
    else $error("command taken from unknown source");

  busy_drop_a: assert property (
    (wr && paddr == `TSC_OFS_CMD && s.state != st_idle)
      |=> $stable(s.band) && $stable(s.ms) && $stable(s.addr_pend))
    else $error("command taken while busy");

  pready_pulse_a: assert property (
    pready |=> !pready)
    else $error("pready held past one cycle");

  bad_addr_err_a: assert property (
    (req && !(paddr inside {`TSC_OFS_CMD, `TSC_OFS_TUNE, `TSC_OFS_PROG,
                            `TSC_OFS_ANA, `TSC_OFS_STAT, `TSC_OFS_WORD}))
      |=> pslverr && pready && prdata == 32'h0000_0000)
    else $error("unmapped offset answered without error");

  store_prog_c: cover property (cmd_ok && cmd == cmd_stprog);
  store_ana_c: cover property (s.state == st_ana_wr ##4 s.state == st_idle);
  norm_remote_c: cover property (cmd_ok && cmd == cmd_norm && src == remote_source);
  post_sel_c: cover property (prog_wr && s.addr_pend);
  skip_defeat_c: cover property (prog_wr && sel_word[0] && option_select_input);
endmodule : tsc_store_unit

// ---- tsc_cmd_src.sv ----
// command source model: keypad, remote and data sources reaching the unit over apb
// assumes calls start right after a rising pclk edge
`timescale 1ns/1ns
module tsc_cmd_src (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // one transfer, then one idle edge; released lines show inverted values
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= ~w;
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask : xfer
endmodule : tsc_cmd_src

// ---- testbench.sv ----
// directed scenarios for the tuning store command unit
// assumes tsc_cmd_src as apb master and a 10 MHz pclk
`timescale 1ns/1ns
`include "tsc_params.svh"
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("FAIL %0t %s", $time, m); end end
module testbench;
  import tsc_pkg::*;
  localparam int HALF = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        option_select_input, analog_enable, display_on;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] tuning_out;
  logic [1:0]  band_out, multi_standard_out;
  logic [23:0] analog_out;
  int          errors, samples_checked, cyc, dark, ana_off;

  tsc_store_unit #(.FLASH_HALF_CYC(HALF)) u_tsc_store_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .option_select_input(option_select_input), .tuning_out(tuning_out),
    .band_out(band_out), .multi_standard_out(multi_standard_out),
    .analog_out(analog_out), .analog_enable(analog_enable), .display_on(display_on));

  tsc_cmd_src u_tsc_cmd_src (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (display_on === 1'b0) dark++;
    if (analog_enable === 1'b0) ana_off++;
    if (cyc == 10000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    logic e;
    u_tsc_cmd_src.xfer(w, a, d, r, e);
    `CHK(e, (a > `TSC_OFS_WORD) ? 1'b1 : 1'b0, "slave error")
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic cmd(input logic [3:0] c, input logic [1:0] s);
    logic [31:0] r;
    wr(`TSC_OFS_CMD, {26'h0, s, c});
    r = 32'h0000_0001;
    // wait out the busy sequence; only the bench timeout ends a hang
    while (r[0] !== 1'b0) bus(1'b0, `TSC_OFS_STAT, 32'h0, r);
  endtask : cmd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input string m);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    `CHK(r, x, m)
  endtask : rd_chk

  // dark cycles since d0 over one whole confirmation flash
  task automatic flash_chk(input int d0);
    repeat (12 * HALF) @(posedge pclk);
    @(negedge pclk);
    `CHK(dark - d0, 5 * HALF, "flash length")
    @(posedge pclk);
  endtask : flash_chk

  task automatic t_reset();
    `CHK(tuning_out, 12'h000, "tuning reset")
    `CHK(analog_enable, 1'b1, "enable reset")
    `CHK(display_on, 1'b1, "display reset")
    rd_chk(8'h18, 32'h0000_0000, "unmapped read");
    $display("test reset done");
  endtask : t_reset

  task automatic t_store();
    int d0;
    wr(`TSC_OFS_PROG, 32'h0000_0003);
    d0 = dark;
    cmd(4'h7, 2'h0);
    rd_chk(`TSC_OFS_WORD, 32'h0000_0001, "skip set");
    flash_chk(d0);
    cmd(4'h1, 2'h2);
    rd_chk(`TSC_OFS_WORD, 32'h0000_0001, "remote store ignored");
    wr(`TSC_OFS_TUNE, {16'h0, 2'b10, 2'b01, 12'habc});
    d0 = dark;
    cmd(4'h1, 2'h0);
    rd_chk(`TSC_OFS_WORD, {15'h0, 2'b01, 2'b10, 12'habc, 1'b0}, "stored word");
    flash_chk(d0);
    $display("test store done");
  endtask : t_store

  task automatic t_seq();
    logic [1:0] b, m;
    b = 2'b10;
    m = 2'b01;
    for (int i = 0; i < 4; i++) begin
      cmd(4'h3, 2'h0);
      b = b + 2'b01;
      `CHK(band_out, b, "band step")
      cmd(4'h4, 2'h0);
      m = m + 2'b01;
      `CHK(multi_standard_out, m, "ms step")
    end
    cmd(4'h3, 2'h1);
    cmd(4'h4, 2'h2);
    `CHK({band_out, multi_standard_out}, {b, m}, "non keypad seq")
    $display("test sequence done");
  endtask : t_seq

  task automatic t_analog();
    int d0, n0;
    wr(`TSC_OFS_ANA, {8'h0, 6'd40, 6'd30, 6'd20, 6'd10});
    d0 = dark;
    wr(`TSC_OFS_CMD, {26'h0, 2'h0, 4'h2});
    // this band step arrives while the analog store is still busy and is dropped
    cmd(4'h3, 2'h0);
    `CHK(band_out, 2'b10, "band step while busy")
    flash_chk(d0);
    wr(`TSC_OFS_ANA, {8'h0, 24'h00_0fc3});
    n0 = ana_off;
    cmd(4'h5, 2'h2);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    `CHK(ana_off - n0, 4, "disabled span")
    `CHK(analog_enable, 1'b1, "enable back")
    `CHK(analog_out, {6'd40, 6'd30, 6'd20, 6'd10}, "reloaded")
    @(posedge pclk);
    n0 = ana_off;
    cmd(4'h5, 2'h3);
    cmd(4'h5, 2'h1);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    `CHK(ana_off - n0, 4, "data normalise span")
    @(posedge pclk);
    $display("test analog done");
  endtask : t_analog

  task automatic t_addr();
    cmd(4'h6, 2'h2);
    rd_chk(`TSC_OFS_STAT, 32'h0000_0004, "remote arm ignored");
    cmd(4'h6, 2'h0);
    wr(`TSC_OFS_TUNE, {16'h0, 2'b00, 2'b11, 12'h5a5});
    wr(`TSC_OFS_PROG, 32'h0000_0005);
    rd_chk(`TSC_OFS_WORD, {15'h0, 2'b11, 2'b00, 12'h5a5, 1'b0}, "post store");
    cmd(4'h7, 2'h0);
    rd_chk(`TSC_OFS_WORD, {15'h0, 2'b11, 2'b00, 12'h5a5, 1'b1}, "skip");
    wr(`TSC_OFS_TUNE, 32'h0000_0123);
    wr(`TSC_OFS_PROG, 32'h0000_0005);
    `CHK(tuning_out, 12'h123, "skipped recall")
    option_select_input <= 1'b1;
    @(posedge pclk);
    wr(`TSC_OFS_PROG, 32'h0000_0005);
    `CHK({multi_standard_out, tuning_out}, {2'b11, 12'h5a5}, "defeat recall")
    option_select_input <= 1'b0;
    @(posedge pclk);
    $display("test addressing done");
  endtask : t_addr

  initial begin
    presetn = 1'b0;
    option_select_input = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_store();
    t_seq();
    t_analog();
    t_addr();
    conclude();
  end
endmodule : testbench
